// *** design/tbdiag_pkg.sv ***
/*
 * tbdiag_pkg: constants and types shared by the terminal-bus diagnostic unit.
 * Assumes a 100 MHz system clock; blink times are given in microseconds.
 */
package tbdiag_pkg;

    localparam int unsigned CLK_MHZ = 100;

    // blink timing in microseconds
    localparam int unsigned FAST_HALF_US = 50_000;
    localparam int unsigned SLOW_HALF_US = 250_000;
    localparam int unsigned PAUSE_US = 1_000_000;
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_US * CLK_MHZ;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_US * CLK_MHZ;
    localparam int unsigned PAUSE_CYC = PAUSE_US * CLK_MHZ;
    localparam int unsigned FAST_PULSES = 8;

    // bus update supervision: expected cycle at most five ms
    localparam int unsigned UPDATE_MAX_US = 5_000;
    localparam int unsigned UPDATE_MAX_CYC = UPDATE_MAX_US * CLK_MHZ;

    // register offsets
    localparam logic [3:0] OFS_STATE = 4'h0;
    localparam logic [3:0] OFS_CTRL = 4'h1;
    localparam logic [3:0] OFS_CODE = 4'h2;

    // state word bit positions
    localparam int unsigned ST_BUS_ERR = 0;
    localparam int unsigned ST_CFG_CHG = 1;
    localparam int unsigned ST_LEN_MIS = 2;
    localparam int unsigned ST_NO_IN = 8;
    localparam int unsigned ST_IN_INC = 9;
    localparam int unsigned ST_OUT_INC = 10;
    localparam int unsigned ST_WDOG = 11;
    localparam int unsigned ST_ACYC = 15;

    // control register bit positions
    localparam int unsigned CT_RESET = 0;

    localparam logic [15:0] STATE_RST = 16'h0000;

    // error codes shown as slow pulses
    localparam logic [3:0] CODE_CMD = 4'h3;
    localparam logic [3:0] CODE_DATA = 4'h4;
    localparam logic [3:0] CODE_REG = 4'h5;
    localparam logic [3:0] CODE_INT = 4'h6;
    localparam logic [3:0] CODE_LEN = 4'h7;
    localparam logic [7:0] ARG_INT_DATA_A = 8'h01;
    localparam logic [7:0] ARG_INT_DATA_B = 8'h08;

    // fault report from the bus engine
    typedef struct packed {
        logic cmdErr;
        logic dataErr;
        logic regErr;
        logic initErr;
        logic intDataErr;
        logic intDataAlt;
        logic lenErr;
        logic emcErr;
        logic latchPower;
        logic [7:0] position;
    } tbdiag_fault_t;

    // register port
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tbdiag_req_t;

    typedef enum logic [4:0] {
        BL_IDLE = 5'b00001,
        BL_FAST = 5'b00010,
        BL_CODE = 5'b00100,
        BL_ARG = 5'b01000,
        BL_GAP = 5'b10000
    } tbdiag_blink_t;

endpackage

// *** design/tbdiag_tick.sv ***
/*
 * tbdiag_tick: divider that gives a one-cycle enable every PERIOD cycles.
 * Assumes a single clock; restart realigns the phase.
 */
module tbdiag_tick #(
    parameter int unsigned PERIOD = 10
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic restart,
    output logic tick
);
    localparam int unsigned W = $clog2(PERIOD + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == W'(PERIOD - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// *** design/tbdiag_pulse.sv ***
/*
 * tbdiag_pulse: emits a train of COUNT on/off pulses timed by an enable.
 * Assumes half-period ticks from a divider; a count of zero ends at once.
 */
module tbdiag_pulse (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic halfTick,
    output logic led,
    output logic done
);
    logic [7:0] left_q;
    logic busy_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= 8'h00;
            busy_q <= 1'b0;
            led <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                left_q <= count;
                busy_q <= (count != 8'h00);
                led <= 1'b0;
                done <= (count == 8'h00);
            end else if (busy_q && halfTick) begin
                if (!led) begin
                    led <= 1'b1;
                end else begin
                    led <= 1'b0;
                    left_q <= left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        busy_q <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// *** design/tbdiag_top.sv ***
/*
 * tbdiag_top: diagnostic unit of a terminal-bus master. Drives the run and
 * error LEDs and keeps the bus state word readable by host software.
 * Assumes the bus engine reports faults and update progress synchronously.
 */
module tbdiag_top
    import tbdiag_pkg::*;
#(
    parameter int unsigned FAST_HALF = FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned PAUSE = PAUSE_CYC,
    parameter int unsigned UPDATE_MAX = UPDATE_MAX_CYC,
    parameter int unsigned FAST_N = FAST_PULSES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire tbdiag_pkg::tbdiag_req_t req,
    output logic [15:0] rdata,
    input wire tbdiag_pkg::tbdiag_fault_t fault,
    input wire logic fieldbusActive,
    input wire logic cfgChanged,
    input wire logic inputsValid,
    input wire logic inUpdateDone,
    input wire logic outUpdateDone,
    input wire logic cycleStart,
    input wire logic watchdog,
    input wire logic taskTick,
    input wire logic acycDone,
    output logic acycReq,
    output logic ledRun,
    output logic ledErr
);
    import tbdiag_pkg::*;

    localparam int unsigned UW = $clog2(UPDATE_MAX + 2);

    // fault capture
    logic errLatched_q;
    logic stickyPower_q;
    logic emc_q;
    logic [3:0] code_q;
    logic [7:0] arg_q;
    logic anyFault;
    logic [3:0] codeNew;
    logic [7:0] argNew;

    // host reset sequencing
    logic clearReq;

    // state word sources
    logic busErr_q;
    logic lenMis_q;
    logic cfgChg_q;
    logic noInputs_q;
    logic wdog_q;
    logic slowCycle_q;
    logic [UW-1:0] updCnt_q;
    logic [15:0] stateWord;

    // blink engine
    tbdiag_blink_t bl_q;
    logic [7:0] trainCount;
    logic trainStart;
    logic trainLed;
    logic trainDone;
    logic fastTick;
    logic slowTick;
    logic gapTick;
    logic gapRestart;
    logic emcTick;

    assign anyFault = fault.cmdErr | fault.dataErr | fault.regErr | fault.initErr
        | fault.intDataErr | fault.lenErr;
    assign clearReq = req.wr && (req.addr == OFS_CTRL) && req.wdata[CT_RESET];

    // fault to code and argument; position already excludes passive terminals
    always_comb begin
        codeNew = 4'h0;
        argNew = 8'h00;
        if (fault.cmdErr) begin
            codeNew = CODE_CMD;
            argNew = 8'h00;
        end else if (fault.dataErr) begin
            codeNew = CODE_DATA;
            argNew = fault.position;
        end else if (fault.regErr) begin
            codeNew = CODE_REG;
            argNew = fault.position;
        end else if (fault.initErr) begin
            codeNew = CODE_INT;
            argNew = 8'h00;
        end else if (fault.intDataErr) begin
            codeNew = CODE_INT;
            argNew = fault.intDataAlt ? ARG_INT_DATA_B : ARG_INT_DATA_A;
        end else if (fault.lenErr) begin
            codeNew = CODE_LEN;
            argNew = 8'h00;
        end
    end

    // first fault is held; a new fault wins over a host clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            errLatched_q <= 1'b0;
            stickyPower_q <= 1'b0;
            code_q <= 4'h0;
            arg_q <= 8'h00;
        end else if (anyFault && !errLatched_q) begin
            errLatched_q <= 1'b1;
            stickyPower_q <= fault.latchPower;
            code_q <= codeNew;
            arg_q <= argNew;
        end else if (acycDone && acycReq && !anyFault && !stickyPower_q) begin
            errLatched_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            emc_q <= 1'b0;
        end else if (fault.emcErr) begin
            emc_q <= 1'b1;
        end
    end

    // non-cyclic reset request to the bus engine
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acycReq <= 1'b0;
        end else if (clearReq) begin
            acycReq <= 1'b1;
        end else if (acycDone) begin
            acycReq <= 1'b0;
        end
    end

    // update cycle supervision and task-overrun detection
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            updCnt_q <= '0;
            slowCycle_q <= 1'b0;
        end else begin
            if (cycleStart) begin
                updCnt_q <= '0;
            end else if (updCnt_q <= UW'(UPDATE_MAX)) begin
                updCnt_q <= updCnt_q + 1'b1;
            end
            if (taskTick) begin
                slowCycle_q <= !(inUpdateDone && outUpdateDone);
            end else if (updCnt_q > UW'(UPDATE_MAX)) begin
                slowCycle_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busErr_q <= 1'b0;
            lenMis_q <= 1'b0;
            cfgChg_q <= 1'b0;
            noInputs_q <= 1'b1;
            wdog_q <= 1'b0;
        end else begin
            busErr_q <= errLatched_q || anyFault;
            lenMis_q <= fault.lenErr || (errLatched_q && code_q == CODE_LEN);
            cfgChg_q <= cfgChg_q || cfgChanged;
            noInputs_q <= noInputs_q && !inputsValid;
            wdog_q <= watchdog;
        end
    end

    // host period limits of 100 ms / 50 ms are the host's concern
    always_comb begin
        stateWord = STATE_RST;
        stateWord[ST_BUS_ERR] = busErr_q;
        stateWord[ST_CFG_CHG] = cfgChg_q;
        stateWord[ST_LEN_MIS] = lenMis_q;
        stateWord[ST_NO_IN] = noInputs_q;
        stateWord[ST_IN_INC] = !inUpdateDone || slowCycle_q;
        stateWord[ST_OUT_INC] = !outUpdateDone || slowCycle_q;
        stateWord[ST_WDOG] = wdog_q;
        stateWord[ST_ACYC] = acycReq;
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                OFS_STATE: rdata <= stateWord;
                OFS_CTRL: rdata <= {15'h0000, acycReq};
                OFS_CODE: rdata <= {4'h0, code_q, arg_q};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // run LED
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ledRun <= 1'b0;
        end else begin
            ledRun <= !errLatched_q && !anyFault && !emc_q && fieldbusActive;
        end
    end

    // rate dividers
    tbdiag_tick #(.PERIOD(FAST_HALF)) u_fast (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(1'b0),
        .tick(fastTick)
    );

    tbdiag_tick #(.PERIOD(SLOW_HALF)) u_slow (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(1'b0),
        .tick(slowTick)
    );

    tbdiag_tick #(.PERIOD(PAUSE)) u_gap (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(gapRestart),
        .tick(gapTick)
    );

    assign emcTick = fastTick;

    tbdiag_pulse u_train (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(trainStart),
        .count(trainCount),
        .halfTick((bl_q == BL_FAST) ? fastTick : slowTick),
        .led(trainLed),
        .done(trainDone)
    );

    // report sequencer
    always_comb begin
        trainStart = 1'b0;
        trainCount = 8'h00;
        gapRestart = 1'b0;
        case (bl_q)
            BL_IDLE: begin
                trainStart = errLatched_q && !emc_q;
                trainCount = 8'(FAST_N);
            end
            BL_FAST: begin
                trainStart = trainDone;
                trainCount = {4'h0, code_q};
            end
            BL_CODE: begin
                trainStart = trainDone;
                trainCount = arg_q;
            end
            BL_ARG: begin
                gapRestart = trainDone;
            end
            BL_GAP: begin
                trainStart = gapTick && errLatched_q;
                trainCount = 8'(FAST_N);
            end
            default: begin
                trainStart = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bl_q <= BL_IDLE;
        end else if (emc_q || !errLatched_q) begin
            // a host clear ends the report at once; sticky errors clear only on reset_n
            bl_q <= BL_IDLE;
        end else begin
            case (bl_q)
                BL_IDLE: begin
                    if (errLatched_q) begin
                        bl_q <= BL_FAST;
                    end
                end
                BL_FAST: begin
                    if (trainDone) begin
                        bl_q <= BL_CODE;
                    end
                end
                BL_CODE: begin
                    if (trainDone) begin
                        bl_q <= BL_ARG;
                    end
                end
                BL_ARG: begin
                    if (trainDone) begin
                        bl_q <= BL_GAP;
                    end
                end
                BL_GAP: begin
                    if (gapTick) begin
                        bl_q <= errLatched_q ? BL_FAST : BL_IDLE;
                    end
                end
                default: bl_q <= BL_IDLE;
            endcase
        end
    end

    // red LED: continuous flashing on interference, else the report train
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ledErr <= 1'b0;
        end else if (emc_q) begin
            if (emcTick) begin
                ledErr <= !ledErr;
            end
        end else begin
            ledErr <= trainLed && (bl_q != BL_IDLE) && (bl_q != BL_GAP);
        end
    end
endmodule

// *** sim/tbdiag_chain.sv ***
/*
 * tbdiag_chain: behavioural terminal chain and bus engine on the far side.
 * Assumes clk_sys and reset_n of the diagnostic unit; slow stalls updates.
 */
module tbdiag_chain (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic acycReq,
    input wire logic slow,
    output logic cycleStart,
    output logic inUpdateDone,
    output logic outUpdateDone,
    output logic inputsValid,
    output logic acycDone
);
    logic [3:0] phase_q;
    logic [3:0] acycCnt_q;

    // one bus update every 16 cycles, finished well inside it; slow stalls the chain
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 4'h0;
            cycleStart <= 1'b0;
            inUpdateDone <= 1'b0;
            outUpdateDone <= 1'b0;
            inputsValid <= 1'b0;
        end else begin
            phase_q <= phase_q + 4'h1;
            cycleStart <= !slow && (phase_q == 4'hf);
            inUpdateDone <= !slow;
            outUpdateDone <= !slow;
            inputsValid <= inputsValid | (!slow && phase_q == 4'h8);
        end
    end

    // non-cyclic reset finishes ten cycles after the request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acycCnt_q <= 4'h0;
            acycDone <= 1'b0;
        end else begin
            acycCnt_q <= (acycReq && acycCnt_q != 4'h9) ? acycCnt_q + 4'h1 : 4'h0;
            acycDone <= (acycCnt_q == 4'h9);
        end
    end
endmodule

// *** sim/tbdiag_top_properties.sv ***
/*
 * tbdiag_top_properties: concurrent checks on the ports of tbdiag_top.
 * Assumes the single clk_sys domain with asynchronous reset_n.
 */
module tbdiag_top_properties
    import tbdiag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire tbdiag_pkg::tbdiag_req_t req,
    input wire logic [15:0] rdata,
    input wire tbdiag_pkg::tbdiag_fault_t fault,
    input wire logic fieldbusActive,
    input wire logic watchdog,
    input wire logic acycDone,
    input wire logic acycReq,
    input wire logic ledRun,
    input wire logic ledErr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_run_needs_link: assert property (!fieldbusActive |=> !ledRun)
        else $error("run led lit without fieldbus link");
    a_run_off_fault: assert property (fault.cmdErr |=> !ledRun)
        else $error("run led lit during a fault");
    a_report_starts: assert property ($rose(fault.cmdErr) && ledRun |-> ##[1:7] ledErr)
        else $error("error report did not start");
    a_emc_flashes: assert property (fault.emcErr && ledRun |-> ##[1:12] ledErr)
        else $error("interference flashing did not start");
    a_reset_request: assert property (
        req.wr && req.addr == OFS_CTRL && req.wdata[CT_RESET] |=> acycReq)
        else $error("reset request not raised");
    a_request_holds: assert property (acycReq && !acycDone |=> acycReq)
        else $error("reset request dropped before completion");
    a_state_acyc: assert property (
        req.rd && req.addr == OFS_STATE && acycReq && $past(acycReq) |=> rdata[ST_ACYC])
        else $error("state word misses non-cyclic flag");
    a_state_buserr: assert property (req.rd && req.addr == OFS_STATE && fault.cmdErr
        && $past(fault.cmdErr) |=> rdata[ST_BUS_ERR])
        else $error("state word misses bus error");
    a_state_wdog: assert property (
        req.rd && req.addr == OFS_STATE && watchdog && $past(watchdog) |=> rdata[ST_WDOG])
        else $error("state word misses watchdog");
    a_read_quiet: assert property (!req.rd |=> rdata == 16'h0000)
        else $error("read data outside read answer");
endmodule

bind tbdiag_top tbdiag_top_properties u_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .req(req), .rdata(rdata), .fault(fault), .fieldbusActive(fieldbusActive),
    .watchdog(watchdog), .acycDone(acycDone), .acycReq(acycReq), .ledRun(ledRun),
    .ledErr(ledErr));

// *** sim/tbdiag_top_test.sv ***
/*
 * tbdiag_top_test: register-port tests of the diagnostic unit with short blink times.
 * Assumes tbdiag_chain as the terminal chain and the bound checker.
 */
module tbdiag_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tbdiag_pkg::*;

    localparam int FH = 4;
    localparam int PS = 20;
    localparam int FN = 3;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    tbdiag_req_t req = '0;
    tbdiag_fault_t fault = '0;
    logic fieldbusActive = 1'b1;
    logic cfgChanged = 1'b0;
    logic watchdog = 1'b0;
    logic taskTick = 1'b0;
    logic slow = 1'b0;
    logic [15:0] rdata;
    logic cycleStart, inUpdateDone, outUpdateDone, inputsValid, acycDone, acycReq;
    logic ledRun, ledErr;
    int failCount = 0;
    int cmpCount = 0;
    int tt = 0;
    int nf, ns;
    logic [15:0] v;
    tbdiag_fault_t fl [8];
    logic [3:0] cd [8] = '{4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h6, 4'h6, 4'h7};
    logic [7:0] ag [8] = '{8'h00, 8'h00, 8'h05, 8'h02, 8'h00, 8'h01, 8'h08, 8'h00};

    always #5 clk_sys = ~clk_sys;

    // host task period of 40 cycles, longer than two bus updates
    always @(posedge clk_sys) begin
        tt <= (tt == 39) ? 0 : tt + 1;
        taskTick <= (tt == 39);
    end

    tbdiag_top #(.FAST_HALF(FH), .SLOW_HALF(8), .PAUSE(PS), .UPDATE_MAX(50), .FAST_N(FN)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .req(req), .rdata(rdata), .fault(fault),
        .fieldbusActive(fieldbusActive), .cfgChanged(cfgChanged), .inputsValid(inputsValid),
        .inUpdateDone(inUpdateDone), .outUpdateDone(outUpdateDone), .cycleStart(cycleStart),
        .watchdog(watchdog), .taskTick(taskTick), .acycDone(acycDone), .acycReq(acycReq),
        .ledRun(ledRun), .ledErr(ledErr));

    tbdiag_chain chain (.clk_sys(clk_sys), .reset_n(reset_n), .acycReq(acycReq), .slow(slow),
        .cycleStart(cycleStart), .inUpdateDone(inUpdateDone), .outUpdateDone(outUpdateDone),
        .inputsValid(inputsValid), .acycDone(acycDone));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic doReset;
        reset_n <= 1'b0;
        cyc(12);
        reset_n <= 1'b1;
    endtask

    // counts fast and slow pulses of one report, ended by a long low stretch
    task automatic report(output int f, output int s);
        int h, l, w;
        f = 0;
        s = 0;
        w = 0;
        l = 0;
        while (ledErr !== 1'b1 && w < 100) begin
            cyc(1);
            w++;
        end
        while (l < PS && w < 400) begin
            h = 0;
            while (ledErr === 1'b1 && h < 50) begin
                cyc(1);
                h++;
            end
            if (h > FH + 1) s++;
            else f++;
            l = 0;
            while (ledErr !== 1'b1 && l < PS) begin
                cyc(1);
                l++;
            end
            w++;
        end
    endtask

    task automatic closeOut;
        $display("comparisons %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        failCount++;
        closeOut();
    end

    initial begin
        fl[0] = '{cmdErr: 1'b1, position: 8'h03, default: '0};
        fl[1] = '{dataErr: 1'b1, default: '0};
        fl[2] = '{dataErr: 1'b1, position: 8'h05, default: '0};
        fl[3] = '{regErr: 1'b1, position: 8'h02, default: '0};
        fl[4] = '{initErr: 1'b1, position: 8'h03, default: '0};
        fl[5] = '{intDataErr: 1'b1, position: 8'h03, default: '0};
        fl[6] = '{intDataErr: 1'b1, intDataAlt: 1'b1, position: 8'h03, default: '0};
        fl[7] = '{lenErr: 1'b1, default: '0};
        doReset();
        rd(OFS_STATE, v);
        chk("no inputs bit", 16'h0100, v & 16'h0100);
        cyc(200);
        rd(OFS_STATE, v);
        chk("idle state", 16'h0000, v);
        chk("run led", 16'h1, {15'h0, ledRun});
        rd(4'hf, v);
        chk("unmapped read", 16'h0000, v);
        wr(OFS_STATE, 16'hffff);
        rd(OFS_STATE, v);
        chk("read-only state", 16'h0000, v);
        fieldbusActive <= 1'b0;
        cyc(3);
        chk("run led no link", 16'h0, {15'h0, ledRun});
        fieldbusActive <= 1'b1;
        watchdog <= 1'b1;
        cyc(3);
        rd(OFS_STATE, v);
        chk("watchdog bit", 16'h0800, v & 16'h0800);
        watchdog <= 1'b0;
        slow <= 1'b1;
        cyc(100);
        rd(OFS_STATE, v);
        chk("slow cycle", 16'h0600, v & 16'h0600);
        slow <= 1'b0;
        cyc(100);
        rd(OFS_STATE, v);
        chk("sync again", 16'h0000, v);
        wr(OFS_CTRL, 16'h0001);
        rd(OFS_CTRL, v);
        chk("request pending", 16'h0001, v & 16'h0001);
        rd(OFS_STATE, v);
        chk("non-cyclic bit", 16'h8000, v & 16'h8000);
        cyc(20);
        rd(OFS_CTRL, v);
        chk("request done", 16'h0000, v & 16'h0001);
        for (int i = 0; i < 8; i++) begin
            fault <= fl[i];
            cyc(2);
            chk("run led fault", 16'h0, {15'h0, ledRun});
            report(nf, ns);
            chk("fast pulses", 16'(FN), 16'(nf));
            chk("slow pulses", 16'(cd[i]) + 16'(ag[i]), 16'(ns));
            rd(OFS_CODE, v);
            chk("report word", {4'h0, cd[i], ag[i]}, v);
            rd(OFS_STATE, v);
            chk("error bits", {13'h0, i == 7, 2'h1}, v & 16'h0005);
            fault <= '0;
            wr(OFS_CTRL, 16'h0001);
            cyc(300);
            rd(OFS_STATE, v);
            chk("error cleared", 16'h0000, v & 16'h0001);
            chk("run led back", 16'h1, {15'h0, ledRun});
        end
        fault <= '{dataErr: 1'b1, latchPower: 1'b1, position: 8'h02, default: '0};
        cyc(10);
        fault <= '0;
        wr(OFS_CTRL, 16'h0001);
        cyc(300);
        rd(OFS_STATE, v);
        chk("latched error", 16'h0001, v & 16'h0001);
        // the first call may join a report midway; the second sees a whole one
        report(nf, ns);
        report(nf, ns);
        chk("still reporting", 16'(FN), 16'(nf));
        chk("latched code", 16'h0006, 16'(ns));
        cfgChanged <= 1'b1;
        cyc(1);
        cfgChanged <= 1'b0;
        cyc(3);
        rd(OFS_STATE, v);
        chk("config bit", 16'h0002, v & 16'h0002);
        doReset();
        // let the run led come up so the interference check has a live start
        cyc(3);
        fault <= '{emcErr: 1'b1, default: '0};
        cyc(1);
        fault <= '0;
        ns = 0;
        v[0] = ledErr;
        repeat (40) begin
            cyc(1);
            if (ledErr !== v[0]) ns++;
            v[0] = ledErr;
        end
        chk("emc flashing", 16'h1, {15'h0, ns >= 8});
        doReset();
        cyc(100);
        chk("clean after reset", 16'h0, {15'h0, ledErr});
        closeOut();
    end
endmodule
